// >>> common/reset_cause_pkg.sv
// Shared constants and carrier types for the reset cause flag logic
package reset_cause_pkg;

    // Reset control register layout
    localparam int RESET_CAUSE_FLAGS_W    = 16;
    localparam int BIT_POR   = 0;
    localparam int BIT_BOR   = 1;
    localparam int BIT_IDLE  = 2;
    localparam int BIT_SLEEP = 3;
    localparam int BIT_WATCHDOG_TIMEOUT_FLAG  = 4;
    localparam int BIT_SWR   = 6;
    localparam int BIT_EXTERNAL_PIN_RESET_FLAG  = 7;
    localparam int BIT_CM    = 9;
    localparam int BIT_ILL   = 14;
    localparam int BIT_TRAP  = 15;

    localparam logic [15:0] RESET_CAUSE_FLAGS_RESET = 16'h0003;
    localparam logic [15:0] RESET_CAUSE_FLAGS_IMPL  = 16'hc2df;
    localparam logic [15:0] BOR_CLEAR  = 16'hc25c;

    // APB byte addresses
    localparam int          ADDR_W        = 12;
    localparam logic [11:0] ADDR_RESET_CAUSE_FLAGS     = 12'h000;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h004;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h008;
    localparam logic [11:0] ADDR_LIVE     = 12'h00c;

    // Internal reset pulse length in clock cycles
    localparam logic [3:0] HOLD_CYCLES = 4'h2;

    localparam logic [7:0] ILLEGAL_OPCODE = 8'h3f;
    localparam int         PC_W           = 24;
    localparam int         WIDX_W         = 4;

    typedef enum logic [0:0] {
        S_RUN  = 1'b0,
        S_HOLD = 1'b1
    } seq_state_t;

    typedef struct packed {
        logic swResetInstr;
        logic wdtExpire;
        logic trapConflict;
        logic sleepInstr;
        logic idleInstr;
        logic clrwdtInstr;
        logic borEvent;
    } cpu_event_t;

    typedef struct packed {
        logic            valid;
        logic [PC_W-1:0] opcode;
    } fetch_t;

    typedef struct packed {
        logic            valid;
        logic            vector;
        logic [PC_W-1:0] target;
    } pc_load_t;

    typedef struct packed {
        logic              valid;
        logic [WIDX_W-1:0] idx;
    } wreg_access_t;

endpackage

// >>> hw/pin_select_shadow.sv
// Hardware shadow copy of the pin-select control registers
`timescale 1ns/1ps
module pin_select_shadow #(
    parameter int NUM_REGS = 8,
    parameter int REG_W    = 16
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      ce,
    // Pin-select side
    input  wire logic [NUM_REGS*REG_W-1:0] liveRegs,
    input  wire logic                      legalUpdate,
    input  wire logic                      resync,
    // Result
    output logic                           mismatch
);
    typedef struct packed {
        logic [NUM_REGS*REG_W-1:0] shadow;
        logic                      primed;
        logic                      mismatch;
    } shadow_state_t;

    shadow_state_t st;
    shadow_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.mismatch = 1'b0;
        // First cycle after power-on only primes, so reset values never trip it
        if (!st.primed || legalUpdate || resync) begin
            next_st.shadow = liveRegs;
            next_st.primed = 1'b1;
        end else begin
            next_st.mismatch = (liveRegs != st.shadow);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign mismatch = st.mismatch;
endmodule

// >>> hw/wreg_init_tracker.sv
// Tracks which working registers have been written since the last reset
`timescale 1ns/1ps
module wreg_init_tracker #(
    parameter int NUM_WREGS = 16,
    parameter int IDX_W     = 4,
    parameter int SP_INDEX  = 15
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    // Core side
    input  wire logic                 clearAll,
    input  wire logic                 wrValid,
    input  wire logic [IDX_W-1:0]     wrIdx,
    input  wire logic                 ptrValid,
    input  wire logic [IDX_W-1:0]     ptrIdx,
    // Results
    output logic                      uninitHit,
    output logic [NUM_WREGS-1:0]      initMask
);
    localparam logic [NUM_WREGS-1:0] SP_ONLY = NUM_WREGS'(1) << SP_INDEX;

    typedef struct packed {
        logic [NUM_WREGS-1:0] written;
    } track_state_t;

    track_state_t st;
    track_state_t next_st;

    always_comb begin
        next_st = st;
        if (clearAll) begin
            next_st.written = SP_ONLY;
        end else if (wrValid) begin
            next_st.written[wrIdx] = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '{written: SP_ONLY};
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign initMask  = st.written;
    assign uninitHit = ptrValid && !st.written[ptrIdx];

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !ce);

    property p_clear_all;
        clearAll |=> (initMask == SP_ONLY);
    endproperty
    a_clear_all: assert property (p_clear_all)
        else $error("working registers not marked uninitialized after reset");
endmodule

// >>> hw/reset_cause_flag_logic.sv
// Reset source detection, reset cause flags and APB register file
`timescale 1ns/1ps
//
// Contract
// - Shadow mismatch of pin-select registers resets device
// - Mismatch reset sets flag bit 9
// - Illegal-condition reset sets flag bit 14
// - Illegal opcode fetch resets device
// - Uninitialized pointer register use resets device
// - Reset clears registers except stack pointer
// - Restricted flow target triggers security reset
// - Branch-type program counter reload is flow change
// - Vector load of program counter is flow change
// - Illegal flag cleared only by power/brown-out or software write
// - Watchdog flag set on expiry, cleared listed
// - Brown-out clears listed flags; pin flag power-only
// - Brown-out flag on both; power flag power-only
// - Software can set and clear every flag
// - Flags stay readable across device resets
module reset_cause_flag_logic #(
    parameter logic [23:0] RESTRICT_LO  = 24'h000200,
    parameter logic [23:0] RESTRICT_HI  = 24'h0003ff,
    parameter int          PS_NUM_REGS  = 8,
    parameter int          PS_REG_W     = 16
) (
    // Clock, enable and power-on reset
    input  wire logic                                      clk,
    input  wire logic                                      rst,
    input  wire logic                                      ce,
    // APB slave
    input  wire logic                                      psel,
    input  wire logic                                      penable,
    input  wire logic                                      pwrite,
    input  wire logic [reset_cause_pkg::ADDR_W-1:0]        paddr,
    input  wire logic [31:0]                               pwdata,
    output logic      [31:0]                               prdata,
    output logic                                           pready,
    output logic                                           pslverr,
    // CPU core events
    input  wire reset_cause_pkg::cpu_event_t               cpuEvents,
    input  wire reset_cause_pkg::fetch_t                   fetch,
    input  wire reset_cause_pkg::pc_load_t                 pcLoad,
    input  wire reset_cause_pkg::wreg_access_t             wregWrite,
    input  wire reset_cause_pkg::wreg_access_t             ptrUse,
    // Pin-select control registers
    input  wire logic [PS_NUM_REGS*PS_REG_W-1:0]           pinSelRegs,
    input  wire logic                                      pinSelUpdate,
    // External reset pin, asynchronous
    input  wire logic                                      externalResetPinN,
    // Outputs
    output logic                                           deviceReset,
    output logic                                           irq
);
    typedef struct packed {
        reset_cause_pkg::seq_state_t fsm;
        logic [3:0]                  holdCnt;
        logic [15:0]                 pending;
        logic [15:0]                 flags;
        logic [15:0]                 irqStat;
        logic [15:0]                 irqMask;
        logic [31:0]                 prdata;
        logic                        pslverr;
        logic                        extSync1;
        logic                        extSync2;
        logic                        extLowPrev;
    } state_t;

    localparam state_t ST_RESET = '{
        fsm:        reset_cause_pkg::S_RUN,
        holdCnt:    4'h0,
        pending:    16'h0000,
        flags:      reset_cause_pkg::RESET_CAUSE_FLAGS_RESET,
        irqStat:    16'h0000,
        irqMask:    16'h0000,
        prdata:     32'h00000000,
        pslverr:    1'b0,
        extSync1:   1'b1,
        extSync2:   1'b1,
        extLowPrev: 1'b0
    };

    // Only the 3Fh upper byte is decoded; full opcode validity lives in the core
    function automatic logic isIllegalOpcode(input logic [23:0] op);
        return op[23:16] == reset_cause_pkg::ILLEGAL_OPCODE;
    endfunction

    function automatic logic inRestricted(input logic [23:0] a);
        return (a >= RESTRICT_LO) && (a <= RESTRICT_HI);
    endfunction

    function automatic logic isMapped(input logic [11:0] a);
        return (a == reset_cause_pkg::ADDR_RESET_CAUSE_FLAGS) || (a == reset_cause_pkg::ADDR_IRQ_STAT) ||
               (a == reset_cause_pkg::ADDR_IRQ_MASK) || (a == reset_cause_pkg::ADDR_LIVE);
    endfunction

    state_t      st;
    state_t      next_st;
    logic        cfgMismatch;
    logic        uninitHit;
    logic        illegalFetch;
    logic        securityHit;
    logic        extLow;
    logic        exitNow;
    logic        wrAccess;
    logic        swWrRcon;
    logic        pwrSave;
    logic [15:0] resetEv;
    logic [15:0] irqSets;

    pin_select_shadow #(
        .NUM_REGS (PS_NUM_REGS),
        .REG_W    (PS_REG_W)
    ) u_shadow (
        .clk         (clk),
        .rst         (rst),
        .ce          (ce),
        .liveRegs    (pinSelRegs),
        .legalUpdate (pinSelUpdate),
        .resync      (deviceReset),
        .mismatch    (cfgMismatch)
    );

    wreg_init_tracker #(
        .NUM_WREGS (16),
        .IDX_W     (reset_cause_pkg::WIDX_W),
        .SP_INDEX  (15)
    ) u_wregs (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .clearAll  (deviceReset),
        .wrValid   (wregWrite.valid),
        .wrIdx     (wregWrite.idx),
        .ptrValid  (ptrUse.valid),
        .ptrIdx    (ptrUse.idx),
        .uninitHit (uninitHit),
        .initMask  ()
    );

    assign illegalFetch = fetch.valid && isIllegalOpcode(fetch.opcode);
    // Both branch-type and vector loads arrive on the same strobe
    assign securityHit  = pcLoad.valid && inRestricted(pcLoad.target);
    assign extLow       = !st.extSync2;
    assign exitNow      = (st.fsm == reset_cause_pkg::S_HOLD) && (st.holdCnt == 4'h0) && !extLow;
    assign wrAccess     = psel && penable && pwrite;
    assign swWrRcon     = wrAccess && (paddr == reset_cause_pkg::ADDR_RESET_CAUSE_FLAGS);
    assign pwrSave      = cpuEvents.sleepInstr || cpuEvents.idleInstr;

    always_comb begin
        resetEv = 16'h0000;
        resetEv[reset_cause_pkg::BIT_CM]   = cfgMismatch;
        resetEv[reset_cause_pkg::BIT_ILL]  = illegalFetch || uninitHit || securityHit;
        resetEv[reset_cause_pkg::BIT_TRAP] = cpuEvents.trapConflict;
        resetEv[reset_cause_pkg::BIT_EXTERNAL_PIN_RESET_FLAG] = extLow && !st.extLowPrev;
        resetEv[reset_cause_pkg::BIT_SWR]  = cpuEvents.swResetInstr;
        resetEv[reset_cause_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = cpuEvents.wdtExpire;
        resetEv[reset_cause_pkg::BIT_BOR]  = cpuEvents.borEvent;
    end

    always_comb begin
        next_st = st;
        next_st.extSync1   = externalResetPinN;
        next_st.extSync2   = st.extSync1;
        next_st.extLowPrev = extLow;

        // Reset sequencer; the cause is latched only once the pulse has run
        case (st.fsm)
            reset_cause_pkg::S_RUN: begin
                if (resetEv != 16'h0000) begin
                    next_st.fsm     = reset_cause_pkg::S_HOLD;
                    next_st.holdCnt = reset_cause_pkg::HOLD_CYCLES - 4'h1;
                    next_st.pending = resetEv;
                end
            end
            reset_cause_pkg::S_HOLD: begin
                if (st.holdCnt != 4'h0) begin
                    next_st.holdCnt = st.holdCnt - 4'h1;
                    next_st.pending = st.pending | resetEv;
                end else if (!exitNow) begin
                    next_st.pending = st.pending | resetEv;
                end else begin
                    next_st.pending = resetEv;
                    if (resetEv == 16'h0000) begin
                        next_st.fsm = reset_cause_pkg::S_RUN;
                    end else begin
                        next_st.holdCnt = reset_cause_pkg::HOLD_CYCLES - 4'h1;
                    end
                end
            end
            default: begin
                next_st.fsm = reset_cause_pkg::S_RUN;
            end
        endcase

        // Flags survive device resets except brown-out, which clears the BOR_CLEAR bits; only power-on reset reinitializes them
        if (swWrRcon) begin
            next_st.flags = pwdata[15:0] & reset_cause_pkg::RESET_CAUSE_FLAGS_IMPL;
        end
        if (cpuEvents.clrwdtInstr || pwrSave) begin
            next_st.flags[reset_cause_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
        end
        if (exitNow) begin
            if (st.pending[reset_cause_pkg::BIT_BOR]) begin
                next_st.flags = next_st.flags & ~reset_cause_pkg::BOR_CLEAR;
            end
            next_st.flags = next_st.flags | st.pending;
        end
        if (cpuEvents.sleepInstr) begin
            next_st.flags[reset_cause_pkg::BIT_SLEEP] = 1'b1;
        end
        if (cpuEvents.idleInstr) begin
            next_st.flags[reset_cause_pkg::BIT_IDLE] = 1'b1;
        end

        // Sticky interrupt status: hardware set beats a same-cycle clear
        irqSets = exitNow ? st.pending : 16'h0000;
        irqSets[reset_cause_pkg::BIT_SLEEP] = irqSets[reset_cause_pkg::BIT_SLEEP] ||
                                              cpuEvents.sleepInstr;
        irqSets[reset_cause_pkg::BIT_IDLE]  = irqSets[reset_cause_pkg::BIT_IDLE] ||
                                              cpuEvents.idleInstr;
        if (wrAccess && (paddr == reset_cause_pkg::ADDR_IRQ_STAT)) begin
            next_st.irqStat = st.irqStat & ~pwdata[15:0];
        end
        next_st.irqStat = (next_st.irqStat | irqSets) & reset_cause_pkg::RESET_CAUSE_FLAGS_IMPL;
        if (wrAccess && (paddr == reset_cause_pkg::ADDR_IRQ_MASK)) begin
            next_st.irqMask = pwdata[15:0] & reset_cause_pkg::RESET_CAUSE_FLAGS_IMPL;
        end

        // Read data and error are captured in the setup phase
        if (psel && !penable) begin
            next_st.pslverr = !isMapped(paddr);
            if (paddr == reset_cause_pkg::ADDR_RESET_CAUSE_FLAGS) begin
                next_st.prdata = {16'h0000, st.flags};
            end else if (paddr == reset_cause_pkg::ADDR_IRQ_STAT) begin
                next_st.prdata = {16'h0000, st.irqStat};
            end else if (paddr == reset_cause_pkg::ADDR_IRQ_MASK) begin
                next_st.prdata = {16'h0000, st.irqMask};
            end else if (paddr == reset_cause_pkg::ADDR_LIVE) begin
                next_st.prdata = {29'h00000000, extLow, cfgMismatch, deviceReset};
            end else begin
                next_st.prdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= ST_RESET;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign deviceReset = (st.fsm == reset_cause_pkg::S_HOLD);
    assign irq         = |(st.irqStat & st.irqMask);
    assign prdata      = st.prdata;
    assign pslverr     = st.pslverr;
    assign pready      = 1'b1;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !ce);

    property p_cm_reset;
        (st.fsm == reset_cause_pkg::S_RUN && cfgMismatch) |=> deviceReset;
    endproperty
    a_cm_reset: assert property (p_cm_reset)
        else $error("mismatch did not reset device");

    property p_cm_flag;
        (exitNow && st.pending[reset_cause_pkg::BIT_CM]) |=> st.flags[reset_cause_pkg::BIT_CM];
    endproperty
    a_cm_flag: assert property (p_cm_flag)
        else $error("mismatch flag not set");

    property p_ill_flag;
        (exitNow && st.pending[reset_cause_pkg::BIT_ILL]) |=> st.flags[reset_cause_pkg::BIT_ILL];
    endproperty
    a_ill_flag: assert property (p_ill_flag)
        else $error("illegal condition flag not set");

    property p_opcode;
        (st.fsm == reset_cause_pkg::S_RUN && illegalFetch) |=> deviceReset ##1 deviceReset;
    endproperty
    a_opcode: assert property (p_opcode)
        else $error("illegal opcode reset too short or missing");

    property p_uninit;
        (st.fsm == reset_cause_pkg::S_RUN && uninitHit) |=>
            (deviceReset && st.pending[reset_cause_pkg::BIT_ILL]);
    endproperty
    a_uninit: assert property (p_uninit)
        else $error("uninitialized pointer use did not reset");

    property p_security;
        (st.fsm == reset_cause_pkg::S_RUN && pcLoad.valid && inRestricted(pcLoad.target)) |=>
            (deviceReset && st.pending[reset_cause_pkg::BIT_ILL]);
    endproperty
    a_security: assert property (p_security)
        else $error("restricted flow target did not reset");

    property p_ill_sticky;
        (st.flags[reset_cause_pkg::BIT_ILL] && !swWrRcon &&
         !(exitNow && st.pending[reset_cause_pkg::BIT_BOR])) |=> st.flags[reset_cause_pkg::BIT_ILL];
    endproperty
    a_ill_sticky: assert property (p_ill_sticky)
        else $error("illegal condition flag cleared by wrong source");

    property p_wdt_clear;
        (cpuEvents.clrwdtInstr && !swWrRcon && !(exitNow && st.pending[reset_cause_pkg::BIT_WATCHDOG_TIMEOUT_FLAG]))
            |=> !st.flags[reset_cause_pkg::BIT_WATCHDOG_TIMEOUT_FLAG];
    endproperty
    a_wdt_clear: assert property (p_wdt_clear)
        else $error("watchdog flag not cleared");

    property p_bor_clear;
        (exitNow && st.pending[reset_cause_pkg::BIT_BOR] && !st.pending[reset_cause_pkg::BIT_SWR] &&
         !st.pending[reset_cause_pkg::BIT_EXTERNAL_PIN_RESET_FLAG] && !swWrRcon) |=>
            (st.flags[reset_cause_pkg::BIT_BOR] && !st.flags[reset_cause_pkg::BIT_SWR] &&
             st.flags[reset_cause_pkg::BIT_EXTERNAL_PIN_RESET_FLAG] == $past(st.flags[reset_cause_pkg::BIT_EXTERNAL_PIN_RESET_FLAG]));
    endproperty
    a_bor_clear: assert property (p_bor_clear)
        else $error("brown-out flag handling wrong");

    property p_sw_write;
        (swWrRcon && !exitNow && !cpuEvents.clrwdtInstr && !pwrSave) |=>
            (st.flags == ($past(pwdata[15:0]) & reset_cause_pkg::RESET_CAUSE_FLAGS_IMPL));
    endproperty
    a_sw_write: assert property (p_sw_write)
        else $error("software write to flags lost");

    property p_hold;
        (st.fsm == reset_cause_pkg::S_RUN && resetEv != 16'h0000) |=>
            (deviceReset && st.flags == $past(st.flags) || swWrRcon) ##1 deviceReset;
    endproperty
    a_hold: assert property (p_hold)
        else $error("device reset pulse shorter than two cycles");

    c_cm_reset: cover property (exitNow && st.pending[reset_cause_pkg::BIT_CM]);
    c_bor_reset: cover property (exitNow && st.pending[reset_cause_pkg::BIT_BOR]);
    c_irq: cover property (irq);
endmodule

// >>> dv/cpu_side_model.sv
// Behavioural core, pin-select and reset pin model
`timescale 1ns/1ps
module cpu_side_model (
    // Clock, reset and command
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     go,
    input  wire logic [3:0]               kind,
    input  wire logic [23:0]              arg,
    // Core side
    output reset_cause_pkg::cpu_event_t   cpuEvents,
    output reset_cause_pkg::fetch_t       fetch,
    output reset_cause_pkg::pc_load_t     pcLoad,
    output reset_cause_pkg::wreg_access_t wregWrite,
    output reset_cause_pkg::wreg_access_t ptrUse,
    // Pin-select registers and pin
    output logic [127:0]                  pinSelRegs,
    output logic                          pinSelUpdate,
    output logic                          externalResetPinN
);
    logic [2:0] pinLow;
    assign externalResetPinN = (pinLow == 3'h0);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cpuEvents <= '0;
            fetch <= '0;
            pcLoad <= '0;
            wregWrite <= '0;
            ptrUse <= '0;
            pinSelRegs <= {8{16'h1f1f}};
            pinSelUpdate <= 1'b0;
            pinLow <= 3'h0;
        end else begin
            // Idle opcode toggles so stale bits never look meaningful
            cpuEvents <= '0;
            fetch <= '{1'b0, ~fetch.opcode};
            pcLoad.valid <= 1'b0;
            wregWrite.valid <= 1'b0;
            ptrUse.valid <= 1'b0;
            pinSelUpdate <= 1'b0;
            pinLow <= (pinLow != 3'h0) ? pinLow - 3'h1 : 3'h0;
            if (go) begin
                case (kind)
                    4'h0: fetch <= '{1'b1, {reset_cause_pkg::ILLEGAL_OPCODE, arg[15:0]}};
                    4'h1: pcLoad <= '{1'b1, 1'b0, arg};
                    4'h2: pcLoad <= '{1'b1, 1'b1, arg};
                    4'h3: ptrUse <= '{1'b1, arg[3:0]};
                    4'h4: wregWrite <= '{1'b1, arg[3:0]};
                    4'h5: pinSelRegs[arg[6:0]] <= ~pinSelRegs[arg[6:0]];
                    4'h6: begin
                        pinSelRegs <= {8{arg[15:0]}};
                        pinSelUpdate <= 1'b1;
                    end
                    4'h7: pinLow <= 3'h4;
                    default: cpuEvents <= 7'(1 << (kind - 4'h8));
                endcase
            end
        end
    end
endmodule

// >>> dv/test_reset_cause_flag_logic.sv
// Self-checking bench for the reset cause flag logic
`timescale 1ns/1ps
module test_reset_cause_flag_logic;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, go = 0, pready, pslverr;
    logic deviceReset, irq, seen, extN, upd;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [3:0] kind = '0;
    logic [23:0] arg = '0;
    logic [15:0] exp;
    logic [127:0] regs;
    reset_cause_pkg::cpu_event_t cpuEv;
    reset_cause_pkg::fetch_t fet;
    reset_cause_pkg::pc_load_t pcl;
    reset_cause_pkg::wreg_access_t wrw, ptr;
    logic [3:0] kinds [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'hc, 4'hd, 4'he};
    int seed = 32'h9283bae8;
    int fail_count = 0, check_count = 0, r, n;
    always #25 clk = ~clk;
    reset_cause_flag_logic dut (.clk(clk), .rst(rst), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpuEvents(cpuEv), .fetch(fet), .pcLoad(pcl),
        .wregWrite(wrw), .ptrUse(ptr), .pinSelRegs(regs), .pinSelUpdate(upd),
        .externalResetPinN(extN), .deviceReset(deviceReset), .irq(irq));
    cpu_side_model partner (.clk(clk), .rst(rst), .go(go), .kind(kind), .arg(arg),
        .cpuEvents(cpuEv), .fetch(fet), .pcLoad(pcl), .wregWrite(wrw), .ptrUse(ptr),
        .pinSelRegs(regs), .pinSelUpdate(upd), .externalResetPinN(extN));
    task check(input logic [31:0] got, input logic [31:0] want);
        check_count++;
        if (got !== want) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        seen = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task rd(input logic [11:0] a, input logic [15:0] want);
        apb(0, a, 32'h0);
        check(prdata, {16'h0, want});
    endtask
    task ev(input logic [3:0] k, input logic [23:0] a);
        @(posedge clk);
        go <= 1; kind <= k; arg <= a;
        @(posedge clk);
        go <= 0;
    endtask
    task waitRst;
        n = 0;
        while (deviceReset !== 1'b1 && n < 20) begin @(posedge clk); n++; end
        check(32'(deviceReset), 32'h1);
        while (deviceReset !== 1'b0 && n < 40) begin @(posedge clk); n++; end
        @(posedge clk);
    endtask
    task noRst;
        n = 0;
        repeat (8) begin @(posedge clk); if (deviceReset !== 1'b0) n++; end
        check(n, 0);
    endtask
    function automatic logic [15:0] causeBit(input logic [3:0] k);
        case (k)
            4'h5: causeBit = 16'h0200;
            4'h7: causeBit = 16'h0080;
            4'hc: causeBit = 16'h8000;
            4'hd: causeBit = 16'h0010;
            4'he: causeBit = 16'h0040;
            default: causeBit = 16'h4000;
        endcase
    endfunction
    task stop_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        stop_test;
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 0;
        rd(reset_cause_pkg::ADDR_RESET_CAUSE_FLAGS, 16'h0003);
        rd(reset_cause_pkg::ADDR_LIVE, 16'h0);
        check(32'(seen), 32'h0);
        rd(12'h010, 16'h0);
        check(32'(seen), 32'h1);
        apb(1, reset_cause_pkg::ADDR_RESET_CAUSE_FLAGS, 32'hffff);
        rd(reset_cause_pkg::ADDR_RESET_CAUSE_FLAGS, 16'hc2df);
        apb(1, reset_cause_pkg::ADDR_RESET_CAUSE_FLAGS, 32'h0);
        rd(reset_cause_pkg::ADDR_RESET_CAUSE_FLAGS, 16'h0);
        apb(1, reset_cause_pkg::ADDR_IRQ_MASK, 32'hffff);
        exp = 16'h0;
        foreach (kinds[i]) begin
            r = $random(seed);
            // Restricted window bounds: low edge fixed, vector target random inside
            ev(kinds[i], kinds[i] == 4'h1 ? 24'h000200 : kinds[i] == 4'h2 ? {15'h1, r[8:0]} :
                kinds[i] == 4'h3 ? {21'h0, r[2:0]} : r[23:0]);
            waitRst;
            exp = exp | causeBit(kinds[i]);
            rd(reset_cause_pkg::ADDR_RESET_CAUSE_FLAGS, exp);
            check(32'(irq), 32'h1);
            apb(1, reset_cause_pkg::ADDR_IRQ_STAT, 32'hffff);
            // Status flop updates on the access edge; look once it has settled
            @(negedge clk);
            check(32'(irq), 32'h0);
        end
        ev(4'h1, 24'h0001ff); noRst;
        ev(4'h2, 24'h000400); noRst;
        r = $random(seed);
        ev(4'h6, r[23:0]); noRst;
        ev(4'h9, 24'h0); noRst;
        exp = exp & 16'hffef;
        rd(reset_cause_pkg::ADDR_RESET_CAUSE_FLAGS, exp);
        ev(4'hd, 24'h0); waitRst;
        ev(4'ha, 24'h0); ev(4'hb, 24'h0); noRst;
        exp = (exp & 16'hffef) | 16'h000c;
        rd(reset_cause_pkg::ADDR_RESET_CAUSE_FLAGS, exp);
        ev(4'h4, 24'h5); ev(4'h3, 24'h5); noRst;
        ev(4'h3, 24'hf); noRst;
        apb(1, reset_cause_pkg::ADDR_IRQ_MASK, 32'h0);
        ev(4'he, 24'h0); waitRst;
        check(32'(irq), 32'h0);
        // Watchdog, idle, sleep and software causes since the last clear
        rd(reset_cause_pkg::ADDR_IRQ_STAT, 16'h005c);
        ev(4'h3, 24'h5); waitRst;
        apb(1, reset_cause_pkg::ADDR_RESET_CAUSE_FLAGS, 32'hffff);
        ev(4'h8, 24'h0); waitRst;
        rd(reset_cause_pkg::ADDR_RESET_CAUSE_FLAGS, 16'h0083);
        stop_test;
    end
endmodule
